//--- rtl/scc_clock_ctrl.sv
// Top of the system clock source control: registers, external drive, clock switch,
// missing-clock detector. Clocks are modelled as levels sampled on ref_clk; the
// reset controller outside latches the missing-clock flag across the reset it causes.
`timescale 1ns/1ps
module scc_clock_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rst_pin_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic osc_pin_in,
  input wire logic xtal_stable,
  output logic osc_pin_in_gnd,
  output logic ext_drive_en,
  output logic [2:0] ext_drive_range,
  output logic int_osc_run,
  output logic sys_clk,
  output logic missing_clock_reset_req,
  output logic missing_clock_reset_flag
);

  typedef struct packed {
    scc_pkg::scc_int_ctrl_type int_ctrl;
    scc_pkg::scc_ext_ctrl_type ext_ctrl;
    logic [7:0] rdata;
    logic pin_s;
    logic pin_prev;
    logic ext_div;
    logic xtal_valid;
    logic gnd;
    logic drive;
    logic int_run;
    scc_pkg::scc_sw_state_type sw;
    logic active_src;
    logic clk_out;
    logic [12:0] mcd_cnt;
    logic mcd_req;
    logic mcd_flag;
  } scc_state_type;

  localparam scc_state_type STATE_RESET = '{
    int_ctrl: scc_pkg::scc_int_ctrl_type'({scc_pkg::INT_CTRL_RESET[7],
                                           scc_pkg::INT_CTRL_RESET[3:0]}),
    ext_ctrl: scc_pkg::scc_ext_ctrl_type'({scc_pkg::EXT_CTRL_RESET[6:4],
                                           scc_pkg::EXT_CTRL_RESET[2:0]}),
    rdata: 8'h00,
    pin_s: 1'b0,
    pin_prev: 1'b0,
    ext_div: 1'b0,
    xtal_valid: 1'b0,
    gnd: 1'b1,
    drive: 1'b0,
    int_run: 1'b0,
    sw: scc_pkg::SCC_RUN,
    active_src: 1'b0,
    clk_out: 1'b0,
    mcd_cnt: 13'h0000,
    mcd_req: 1'b0,
    mcd_flag: 1'b0
  };

  scc_state_type state_reg;
  scc_state_type state_next;

  logic int_clk;
  logic int_ready;
  logic int_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator

  assign int_enable = state_reg.int_ctrl.internal_osc_enable && rst_pin_n;

  scc_int_osc u_int_osc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(int_enable),
    .freq_code(state_reg.int_ctrl.internal_freq_code),
    .osc_clk(int_clk),
    .ready(int_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [1:0] ext_kind;
    logic ext_clk;
    logic src_clk;
    logic new_clk;
    logic wr_int;
    logic wr_ext;
    ext_kind = 2'h0;
    ext_clk = 1'b0;
    src_clk = 1'b0;
    new_clk = 1'b0;
    wr_int = 1'b0;
    wr_ext = 1'b0;

    state_next = state_reg;
    state_next.mcd_req = 1'b0;
    ext_kind = state_reg.ext_ctrl.external_mode_field[2:1];

    // Register writes
    wr_int = reg_wr && (reg_addr == scc_pkg::INT_CTRL_ADDR);
    wr_ext = reg_wr && (reg_addr == scc_pkg::EXT_CTRL_ADDR);
    if (wr_int)
    begin
      state_next.int_ctrl.missing_clock_enable = reg_wdata[scc_pkg::INT_MCD_EN_BIT];
      state_next.int_ctrl.clock_source_select = reg_wdata[scc_pkg::INT_SEL_BIT];
      state_next.int_ctrl.internal_osc_enable = reg_wdata[scc_pkg::INT_EN_BIT];
      state_next.int_ctrl.internal_freq_code = reg_wdata[scc_pkg::INT_CODE_LSB +: 2];
    end
    if (wr_ext)
    begin
      state_next.ext_ctrl.external_mode_field = reg_wdata[scc_pkg::EXT_MODE_LSB +: 3];
      state_next.ext_ctrl.external_range_code = reg_wdata[scc_pkg::EXT_RANGE_LSB +: 3];
    end

    // Register reads, data in the following cycle
    state_next.rdata = 8'h00;
    if (reg_rd && (reg_addr == scc_pkg::INT_CTRL_ADDR))
    begin
      state_next.rdata[scc_pkg::INT_MCD_EN_BIT] = state_reg.int_ctrl.missing_clock_enable;
      state_next.rdata[scc_pkg::INT_READY_BIT] = int_ready;
      state_next.rdata[scc_pkg::INT_SEL_BIT] = state_reg.int_ctrl.clock_source_select;
      state_next.rdata[scc_pkg::INT_EN_BIT] = state_reg.int_ctrl.internal_osc_enable;
      state_next.rdata[scc_pkg::INT_CODE_LSB +: 2] = state_reg.int_ctrl.internal_freq_code;
    end
    else if (reg_rd && (reg_addr == scc_pkg::EXT_CTRL_ADDR))
    begin
      state_next.rdata[scc_pkg::EXT_VALID_BIT] = state_reg.xtal_valid;
      state_next.rdata[scc_pkg::EXT_MODE_LSB +: 3] = state_reg.ext_ctrl.external_mode_field;
      state_next.rdata[scc_pkg::EXT_RANGE_LSB +: 3] = state_reg.ext_ctrl.external_range_code;
    end

    if (!rst_pin_n)
    begin
      state_next.int_ctrl = STATE_RESET.int_ctrl;
      state_next.ext_ctrl = STATE_RESET.ext_ctrl;
      ext_kind = scc_pkg::EXT_OFF;
    end

    ////////////////////////////////////////////////////////////////////////
    // External oscillator path

    state_next.gnd = (ext_kind == scc_pkg::EXT_OFF);
    state_next.drive = (ext_kind == scc_pkg::EXT_RC) || (ext_kind == scc_pkg::EXT_XTAL);
    state_next.int_run = int_enable;
    state_next.xtal_valid = (ext_kind == scc_pkg::EXT_XTAL) && xtal_stable;
    state_next.pin_s = (ext_kind != scc_pkg::EXT_OFF) && osc_pin_in;
    state_next.pin_prev = state_reg.pin_s;
    if (ext_kind == scc_pkg::EXT_OFF)
    begin
      state_next.ext_div = 1'b0;
    end
    else if (state_reg.pin_s && !state_reg.pin_prev)
    begin
      state_next.ext_div = !state_reg.ext_div;
    end
    if (scc_pkg::ext_divided(state_reg.ext_ctrl.external_mode_field))
    begin
      ext_clk = state_reg.ext_div;
    end
    else
    begin
      ext_clk = state_reg.pin_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source switch

    src_clk = state_reg.active_src ? ext_clk : int_clk;
    new_clk = state_reg.int_ctrl.clock_source_select ? ext_clk : int_clk;
    unique case (state_reg.sw)
      scc_pkg::SCC_RUN:
      begin
        if ((state_reg.int_ctrl.clock_source_select != state_reg.active_src)
            && !state_reg.clk_out && !src_clk)
        begin
          state_next.sw = scc_pkg::SCC_PARK;
          state_next.clk_out = 1'b0;
        end
        else
        begin
          state_next.clk_out = src_clk;
        end
      end
      scc_pkg::SCC_PARK:
      begin
        state_next.clk_out = 1'b0;
        if (!new_clk)
        begin
          state_next.active_src = state_reg.int_ctrl.clock_source_select;
          state_next.sw = scc_pkg::SCC_RUN;
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Missing-clock detector

    if (!state_reg.int_ctrl.missing_clock_enable || (state_next.clk_out != state_reg.clk_out))
    begin
      state_next.mcd_cnt = 13'h0000;
    end
    else if (state_reg.mcd_cnt != scc_pkg::MCD_CYCLES)
    begin
      state_next.mcd_cnt = state_reg.mcd_cnt + 13'h0001;
      if (state_reg.mcd_cnt + 13'h0001 == scc_pkg::MCD_CYCLES)
      begin
        state_next.mcd_req = 1'b1;
        state_next.mcd_flag = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign osc_pin_in_gnd = state_reg.gnd;
  assign ext_drive_en = state_reg.drive;
  assign ext_drive_range = state_reg.ext_ctrl.external_range_code;
  assign int_osc_run = state_reg.int_run;
  assign sys_clk = state_reg.clk_out;
  assign missing_clock_reset_req = state_reg.mcd_req;
  assign missing_clock_reset_flag = state_reg.mcd_flag;

endmodule : scc_clock_ctrl

//--- inc/scc_pkg.sv
// Constants, register map and carrier types of the system clock source control.
// Assumes a 40 MHz ref_clk and an 8-bit register port with one-cycle read latency.
//
// Overview of operation
// - Any reset selects the internal oscillator
// - Reset pin low disables both oscillators
// - Source select bit 3 picks internal/external
// - Enable bit 7 arms the missing-clock reset
// - Missing-clock reset fires within 100-500 us
// - Ready bit 4 set only at programmed speed
// - Enable bit starts or stops internal oscillator
// - Frequency code picks 2/4/8/16 MHz; the model runs 2/4/10/20 MHz
// - Bits 6-5 read zero, writes ignored
// - Crystal valid bit 7 shows stable crystal
// - Mode field bits 6-4 picks external source
// - Modes 011, 10x, 111 halve external clock
// - Mode 00x stops drive, grounds first pin
// - CMOS modes take clock from first pin
// - External bit 3 reserved, writes ignored
// - Range code bits 2-0 sets drive range
// - Missing-clock reset sets flag, not pin
package scc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] INT_CTRL_ADDR = 8'hB2;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'hB3;
  localparam logic [7:0] INT_CTRL_RESET = 8'h14;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h00;

  // Internal oscillator control fields
  localparam int INT_MCD_EN_BIT = 7;
  localparam int INT_READY_BIT = 4;
  localparam int INT_SEL_BIT = 3;
  localparam int INT_EN_BIT = 2;
  localparam int INT_CODE_LSB = 0;

  // External oscillator control fields
  localparam int EXT_VALID_BIT = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_RANGE_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int REF_CLK_KHZ = 40000;
  localparam int MCD_MIN_US = 100;
  localparam int MCD_MAX_US = 500;
  localparam int MCD_CYCLES_INT = (MCD_MIN_US * REF_CLK_KHZ + 999) / 1000;
  localparam logic [12:0] MCD_CYCLES = 13'(MCD_CYCLES_INT);
  // Settling time of the internal oscillator after enable or code change
  localparam logic [4:0] INT_SETTLE_CYCLES = 5'h10;
  // Nominal internal frequencies in kHz per code
  localparam int INT_F0_KHZ = 2000;
  localparam int INT_F1_KHZ = 4000;
  localparam int INT_F2_KHZ = 8000;
  localparam int INT_F3_KHZ = 16000;
  // Half periods in ref_clk cycles, rounded down, at least one
  localparam logic [3:0] INT_HALF0 = 4'(REF_CLK_KHZ / (2 * INT_F0_KHZ));
  localparam logic [3:0] INT_HALF1 = 4'(REF_CLK_KHZ / (2 * INT_F1_KHZ));
  localparam logic [3:0] INT_HALF2 = 4'(REF_CLK_KHZ / (2 * INT_F2_KHZ));
  localparam logic [3:0] INT_HALF3 = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // External modes (upper two bits of the mode field)
  localparam logic [1:0] EXT_OFF = 2'h0;
  localparam logic [1:0] EXT_CMOS = 2'h1;
  localparam logic [1:0] EXT_RC = 2'h2;
  localparam logic [1:0] EXT_XTAL = 2'h3;

  typedef struct packed {
    logic missing_clock_enable;
    logic clock_source_select;
    logic internal_osc_enable;
    logic [1:0] internal_freq_code;
  } scc_int_ctrl_type;

  typedef struct packed {
    logic [2:0] external_mode_field;
    logic [2:0] external_range_code;
  } scc_ext_ctrl_type;

  typedef enum logic {
    SCC_RUN,
    SCC_PARK
  } scc_sw_state_type;

  function automatic logic [3:0] half_period(input logic [1:0] code);
    case (code)
      2'h0: half_period = INT_HALF0;
      2'h1: half_period = INT_HALF1;
      2'h2: half_period = INT_HALF2;
      default: half_period = INT_HALF3;
    endcase
  endfunction : half_period

  // Modes that route the external clock through the divide-by-two stage
  function automatic logic ext_divided(input logic [2:0] mode);
    ext_divided = (mode == 3'h3) || (mode[2:1] == EXT_RC) || (mode == 3'h7);
  endfunction : ext_divided

endpackage : scc_pkg

//--- rtl/scc_int_osc.sv
// Behavioural model of the programmable internal oscillator as a toggling level.
// Assumes enable already combines the software enable with the reset pin.
`timescale 1ns/1ps
module scc_int_osc (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [1:0] freq_code,
  output logic osc_clk,
  output logic ready
);

  typedef struct packed {
    logic [3:0] cnt;
    logic clk;
    logic rdy;
    logic [4:0] settle;
    logic [1:0] code_seen;
  } scc_osc_state_type;

  scc_osc_state_type state_reg;
  scc_osc_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.code_seen = freq_code;
    if (!enable)
    begin
      state_next.cnt = 4'h0;
      state_next.clk = 1'b0;
      state_next.rdy = 1'b0;
      state_next.settle = 5'h00;
    end
    else
    begin
      if (state_reg.cnt + 4'h1 >= scc_pkg::half_period(freq_code))
      begin
        state_next.cnt = 4'h0;
        state_next.clk = !state_reg.clk;
      end
      else
      begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
      if (freq_code != state_reg.code_seen)
      begin
        state_next.rdy = 1'b0;
        state_next.settle = 5'h00;
      end
      else if (state_reg.settle == scc_pkg::INT_SETTLE_CYCLES)
      begin
        state_next.rdy = 1'b1;
      end
      else
      begin
        state_next.settle = state_reg.settle + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '{cnt: 4'h0, clk: 1'b0, rdy: 1'b1, settle: 5'h10, code_seen: 2'h0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign osc_clk = state_reg.clk;
  assign ready = state_reg.rdy;

endmodule : scc_int_osc

//--- testbench/scc_ext_src.sv
// Model of the source on the oscillator pins: CMOS clock or oscillator output.
// Assumes the bench gates the clock with run; the crystal settles after drive is on.
`timescale 1ns/1ps
module scc_ext_src #(
  parameter int HALF = 4,
  parameter int STABLE = 200
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic ext_drive_en,
  input wire logic osc_pin_in_gnd,
  output logic osc_pin_in,
  output logic xtal_stable
);
  logic lvl;
  int ph;
  int st;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lvl <= 1'b0;
      ph <= 0;
      st <= 0;
    end
    else
    begin
      if (run)
      begin
        ph <= (ph >= HALF - 1) ? 0 : ph + 1;
        lvl <= (ph >= HALF - 1) ? ~lvl : lvl;
      end
      st <= !ext_drive_en ? 0 : (st < STABLE ? st + 1 : st);
    end
  end
  assign osc_pin_in = osc_pin_in_gnd ? 1'b0 : lvl;
  assign xtal_stable = (st >= STABLE);
endmodule : scc_ext_src

//--- testbench/scc_chk.sv
// Assertions on the ports of the clock source control.
// Assumes one ref_clk domain; bound onto every scc_clock_ctrl.
`timescale 1ns/1ps
module scc_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rst_pin_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_pin_in,
  input wire logic xtal_stable,
  input wire logic osc_pin_in_gnd,
  input wire logic ext_drive_en,
  input wire logic [2:0] ext_drive_range,
  input wire logic int_osc_run,
  input wire logic sys_clk,
  input wire logic missing_clock_reset_req,
  input wire logic missing_clock_reset_flag
);
  localparam int STALL_LO = 3996;
  localparam int STALL_HI = 4010;
  logic prev_clk;
  logic [15:0] stall_cnt;
  logic ext_wr;
  assign ext_wr = reg_wr && rst_pin_n && reg_addr == scc_pkg::EXT_CTRL_ADDR;
  // Cycles since the last system clock change
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_clk <= 1'b0;
      stall_cnt <= 16'h0;
    end
    else
    begin
      prev_clk <= sys_clk;
      stall_cnt <= (sys_clk != prev_clk) ? 16'h0 : (stall_cnt == 16'hFFFF ? stall_cnt : stall_cnt + 16'h1);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  chk_pin_off: assert property (!rst_pin_n ##1 !rst_pin_n |=> osc_pin_in_gnd && !ext_drive_en && !int_osc_run)
    else $error("oscillator active while reset pin low");
  chk_unused_zero: assert property (reg_rd && reg_addr == scc_pkg::INT_CTRL_ADDR |=> reg_rdata[6:5] == 2'h0)
    else $error("unused internal bits read nonzero");
  chk_resv_zero: assert property (reg_rd && reg_addr == scc_pkg::EXT_CTRL_ADDR |=> reg_rdata[3] == 1'b0)
    else $error("reserved external bit read nonzero");
  chk_range_copy: assert property (ext_wr ##1 !reg_wr |=> ext_drive_range == $past(reg_wdata[2:0], 2))
    else $error("drive range differs from written code");
  chk_mode_drive: assert property (ext_wr ##1 !reg_wr |=> osc_pin_in_gnd == ($past(reg_wdata[6:5], 2) == 2'h0) &&
    ext_drive_en == $past(reg_wdata[6], 2))
    else $error("pin ground or drive wrong for mode");
  chk_req_once: assert property (missing_clock_reset_req |=> !missing_clock_reset_req && missing_clock_reset_flag)
    else $error("reset request not a single pulse with flag");
  chk_flag_hold: assert property (missing_clock_reset_flag |=> missing_clock_reset_flag)
    else $error("missing clock flag dropped");
  chk_stall_win: assert property (missing_clock_reset_req |-> stall_cnt >= STALL_LO && stall_cnt <= STALL_HI)
    else $error("reset request outside stall window");
  cover property (missing_clock_reset_req);
  cover property (ext_wr ##2 ext_drive_en);
  cover property (!rst_pin_n ##1 rst_pin_n);
endmodule : scc_chk
bind scc_clock_ctrl scc_chk scc_chk_i (.ref_clk(ref_clk), .rstn(rstn), .rst_pin_n(rst_pin_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .osc_pin_in(osc_pin_in), .xtal_stable(xtal_stable), .osc_pin_in_gnd(osc_pin_in_gnd),
  .ext_drive_en(ext_drive_en), .ext_drive_range(ext_drive_range), .int_osc_run(int_osc_run),
  .sys_clk(sys_clk), .missing_clock_reset_req(missing_clock_reset_req),
  .missing_clock_reset_flag(missing_clock_reset_flag));

//--- testbench/scc_clock_ctrl_tb.sv
// Self-checking bench of the clock source control through its register port.
// Assumes the external source model and the bound checker.
`timescale 1ns/1ps
module scc_clock_ctrl_tb;
  localparam logic [7:0] AI = scc_pkg::INT_CTRL_ADDR;
  localparam logic [7:0] AX = scc_pkg::EXT_CTRL_ADDR;
  logic ref_clk = 0, rstn = 0, rst_pin_n = 1, reg_wr = 0, reg_rd = 0, run = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic osc_pin_in, xtal_stable, osc_pin_in_gnd, ext_drive_en, int_osc_run, sys_clk, mreq, mflag;
  logic [2:0] ext_drive_range;
  int err_count = 0, samples_checked = 0, c, i, cd;
  int tog_exp[4] = '{4, 8, 20, 40};
  int mlist[5] = '{2, 3, 5, 6, 7};
  int mexp[5] = '{20, 10, 10, 20, 10};
  always #12.5 ref_clk = ~ref_clk;
  scc_clock_ctrl scc_clock_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .rst_pin_n(rst_pin_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_pin_in(osc_pin_in),
    .xtal_stable(xtal_stable), .osc_pin_in_gnd(osc_pin_in_gnd), .ext_drive_en(ext_drive_en),
    .ext_drive_range(ext_drive_range), .int_osc_run(int_osc_run), .sys_clk(sys_clk),
    .missing_clock_reset_req(mreq), .missing_clock_reset_flag(mflag));
  scc_ext_src scc_ext_src_i (.ref_clk(ref_clk), .rstn(rstn), .run(run), .ext_drive_en(ext_drive_en),
    .osc_pin_in_gnd(osc_pin_in_gnd), .osc_pin_in(osc_pin_in), .xtal_stable(xtal_stable));
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e, input string msg);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e, msg);
  endtask : rd
  // Counts system clock changes over n cycles
  task tog(input int n, output int cnt);
    logic p;
    @(posedge ref_clk);
    #1;
    p = sys_clk;
    cnt = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      cnt += (sys_clk !== p);
      p = sys_clk;
    end
  endtask : tog
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(12);
    rstn <= 1'b1;
    run <= 1'b1;
    cyc(2);
    rd(AI, 8'h14, "internal reset value");
    rd(AX, 8'h00, "external reset value");
    rd(8'h40, 8'h00, "unmapped read");
    for (int k = 0; k < 4; k++)
    begin
      cd = 3 - k;
      wr(AI, 8'h64 | 8'(cd));
      rd(AI, 8'h04 | 8'(cd), "ready after code change");
      cyc(20);
      rd(AI, 8'h14 | 8'(cd), "ready after settling");
      tog(40, c);
      chk(c == tog_exp[cd], "internal rate");
    end
    wr(AI, 8'h00);
    cyc(2);
    chk(int_osc_run === 1'b0, "internal still running");
    rd(AI, 8'h00, "disabled readback");
    tog(40, c);
    chk(c == 0, "clock while disabled");
    wr(AI, 8'h14);
    cyc(20);
    for (int m = 0; m < 8; m++)
    begin
      wr(AX, 8'h8D | 8'(m << 4));
      rd(AX, 8'h05 | 8'(m << 4), "external readback");
      chk(osc_pin_in_gnd === (m < 2) && ext_drive_en === (m >= 4), "pin mode");
    end
    for (int j = 0; j < 5; j++)
    begin
      wr(AI, 8'h14);
      wr(AX, 8'(mlist[j] << 4));
      if (mlist[j] == 6)
      begin
        cyc(40000);
        rd(AX, 8'hE0, "crystal valid");
      end
      wr(AI, 8'h1C);
      cyc(40);
      tog(80, c);
      chk(c == mexp[j], "external rate");
    end
    wr(AI, 8'h14);
    cyc(40);
    tog(40, c);
    chk(c == 4, "back on internal");
    wr(AX, 8'h20);
    wr(AI, 8'h1C);
    cyc(40);
    run <= 1'b0;
    cyc(4500);
    chk(mflag === 1'b0, "detector fired while off");
    run <= 1'b1;
    wr(AI, 8'h9C);
    cyc(40);
    run <= 1'b0;
    for (i = 0; i < 6000 && mreq !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk(i >= 3994 && i <= 4010, "detector delay");
    if (i == 6000)
      end_of_test;
    cyc(2);
    chk(mflag === 1'b1, "flag not set");
    run <= 1'b1;
    rst_pin_n <= 1'b0;
    cyc(3);
    chk(!int_osc_run && !ext_drive_en && osc_pin_in_gnd, "oscillators on in pin reset");
    rst_pin_n <= 1'b1;
    cyc(20);
    chk(mflag === 1'b1, "flag cleared by pin");
    rd(AI, 8'h14, "internal after pin reset");
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(2);
    chk(mflag === 1'b0, "flag after reset");
    rd(AI, 8'h14, "internal after reset");
    end_of_test;
  end
endmodule : scc_clock_ctrl_tb
